// *** pkg/ccs_pkg.sv ***
package ccs_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] CTL_OFS    = 8'h00;
   localparam logic [7:0] CFG0_OFS   = 8'h08;
   localparam logic [7:0] INT_OFS    = 8'h0C;
   localparam logic [7:0] LRC_OFS    = 8'h10;
   localparam logic [7:0] DSV_OFS    = 8'h14;
   localparam logic [7:0] VKEY_OFS   = 8'h18;

   // main control register fields
   localparam int CTL_READY_BIT   = 31;
   localparam int CTL_PU_BIT      = 28;
   localparam int CTL_PLLSTB_BIT  = 23;
   localparam int CTL_MONEN_BIT   = 22;
   localparam int CTL_PLLEN_BIT   = 21;
   localparam int CTL_XSTB_BIT    = 17;
   localparam int CTL_XEN_BIT     = 16;
   localparam int CTL_ADJ_LSB     = 3;
   localparam int CTL_FSTB_BIT    = 1;
   localparam int CTL_FEN_BIT     = 0;

   // configuration register fields
   localparam int CFG_SW_LSB      = 0;
   localparam int CFG_STAT_LSB    = 2;
   localparam int CFG_ASEL_LSB    = 4;
   localparam int CFG_ADIV_LSB    = 8;
   localparam int CFG_BSEL_LSB    = 12;
   localparam int CFG_BDIV_LSB    = 16;

   // interrupt register fields
   localparam int INT_LRCF_BIT    = 0;
   localparam int INT_CKMF_BIT    = 7;
   localparam int INT_LRCIE_BIT   = 8;
   localparam int INT_LRCCLR_BIT  = 16;
   localparam int INT_CKMCLR_BIT  = 23;

   // low-speed rc register fields
   localparam int LRC_EN_BIT      = 0;
   localparam int LRC_STB_BIT     = 1;

   // values after reset
   localparam logic       MONEN_RST = 1'b1;
   localparam logic       FEN_RST   = 1'b1;
   localparam logic [4:0] ADJ_RST   = 5'h10;
   localparam logic [1:0] DSV_RST   = 2'h0;

   localparam logic [31:0] VKEY_UNLOCK = 32'h1A2B_3C4D;

   // deep-sleep core level codes: 1.1 V, 1.0 V, 0.9 V
   localparam logic [1:0] LVL_1V1 = 2'h0;
   localparam logic [1:0] LVL_1V0 = 2'h1;
   localparam logic [1:0] LVL_0V9 = 2'h2;

   // system clock source, gray along rc -> crystal -> pll
   typedef enum logic [1:0] {
      CCS_SRC_RC   = 2'b00,
      CCS_SRC_XTAL = 2'b01,
      CCS_SRC_PLL  = 2'b11,
      CCS_SRC_RSV  = 2'b10
   } ccs_src_t;

endpackage

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_top;
   logic        clk_i       = 1'b0;
   logic        rst_i       = 1'b1;
   logic        cyc         = 1'b0;
   logic        stb         = 1'b0;
   logic        we          = 1'b0;
   logic [7:0]  adr         = 8'h00;
   logic [3:0]  sel         = 4'h0;
   logic [31:0] wdat        = 32'h0000_0000;
   logic        xstb        = 1'b0;
   logic        pstb        = 1'b0;
   logic        lstb        = 1'b0;
   logic        stuck       = 1'b0;
   logic        sleep       = 1'b0;
   logic [4:0]  lv          = 5'h00;   // {lrc, pll, crystal, slow crystal, fast rc}
   logic [31:0] rdat, q;
   logic        ack, frc_en, xen, xpu, xrdy, pen, mon, lrc_en, lirq, nmi, ca, cb, pa, pb;
   logic [1:0]  src, dlvl;
   logic [4:0]  trim;
   logic [1:0]  pipe [$];
   int          fail_count  = 0;
   int          comparisons = 0;
   int          cycles      = 0;
   int          n, na, nb;
   integer      seed        = 32'h0000_0749;

   always #4 clk_i = ~clk_i;

   ccs_top i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .frc_stable_i(1'b1), .xtal_stable_i(xstb),
      .pll_stable_i(pstb), .lrc_stable_i(lstb), .pll_ref_xtal_i(1'b1), .xtal_stuck_i(stuck),
      .sleep_entry_i(sleep), .frc_lvl_i(lv[0]), .sxtal_lvl_i(lv[1]), .xtal_lvl_i(lv[2]),
      .pll_lvl_i(lv[3]), .lrc_lvl_i(lv[4]), .frc_en_o(frc_en), .xtal_en_o(xen), .xtal_pu_o(xpu),
      .xtal_ready_o(xrdy), .pll_en_o(pen), .mon_en_o(mon), .lrc_en_o(lrc_en), .sysclk_src_o(src),
      .lrc_irq_o(lirq), .nmi_o(nmi), .clkout_a_o(ca), .clkout_b_o(cb), .dsleep_level_o(dlvl),
      .frc_trim_o(trim)
   );

   task end_sim;
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // a hang anywhere ends the run as a failure
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         end_sim();
      end
   end

   // one classic cycle; returns at the ack edge with read data in q
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wait_n(input int k);
      repeat (k) @(negedge clk_i);
   endtask

   // sysclk runs from fast rc during the mux checks
   function automatic logic exp_a(input int c, input logic [4:0] v);
      // reserved codes drive the pin low
      return (c > 5) ? 1'b0 : (c == 5) ? v[0] : v[c];
   endfunction

   function automatic logic exp_b(input int c, input logic [4:0] v);
      return (c < 2) ? v[0] : v[c];
   endfunction

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ccs_pkg::CTL_OFS, 4'hF, 32'h0000_0000);
      `CHK(q, 32'h0040_0083)
      `CHK({src, frc_en, mon, trim}, 9'b0_0111_0000)
      wb(1'b1, ccs_pkg::CTL_OFS, 4'hF, 32'h90C0_0083);
      wb(1'b0, ccs_pkg::CTL_OFS, 4'hF, 32'h0000_0000);
      `CHK(q, 32'h9040_0083)
      wb(1'b1, ccs_pkg::CTL_OFS, 4'b0100, 32'h0041_0000);
      wait_n(1);
      `CHK(xen, 1'b1)
      wb(1'b1, ccs_pkg::CTL_OFS, 4'hF, 32'h0041_0083);
      wait_n(1);
      `CHK({xrdy, xpu}, 2'b11)
      wb(1'b1, ccs_pkg::CFG0_OFS, 4'hF, 32'h0000_0001);
      wait_n(5);
      `CHK(src, 2'b00)
      @(posedge clk_i);
      xstb <= 1'b1;
      wait_n(3);
      `CHK(src, 2'b01)
      wb(1'b1, ccs_pkg::CTL_OFS, 4'hF, 32'h9040_0083);
      wait_n(1);
      `CHK(xen, 1'b1)
      wb(1'b1, ccs_pkg::CTL_OFS, 4'hF, 32'h9061_0083);
      @(posedge clk_i);
      pstb <= 1'b1;
      wb(1'b1, ccs_pkg::CFG0_OFS, 4'hF, 32'h0000_0003);
      wait_n(3);
      `CHK({pen, src}, 3'b111)
      wb(1'b1, ccs_pkg::CTL_OFS, 4'hF, 32'h9040_0082);
      wait_n(1);
      `CHK({pen, xen, frc_en}, 3'b110)
      @(posedge clk_i);
      stuck <= 1'b1;
      pstb  <= 1'b0;
      xstb  <= 1'b0;
      n = 0;
      repeat (4) begin
         @(negedge clk_i);
         n += int'(nmi === 1'b1);
      end
      `CHK(n, 1)
      `CHK({xen, frc_en, pen, src}, 5'b01000)
      @(posedge clk_i);
      stuck <= 1'b0;
      wb(1'b0, ccs_pkg::INT_OFS, 4'hF, 32'h0000_0000);
      `CHK(q[ccs_pkg::INT_CKMF_BIT], 1'b1)
      wb(1'b1, ccs_pkg::INT_OFS, 4'hF, 32'h0080_0000);
      wb(1'b0, ccs_pkg::INT_OFS, 4'hF, 32'h0000_0000);
      `CHK(q[ccs_pkg::INT_CKMF_BIT], 1'b0)
      // crystal on with the monitor off: a stuck crystal is ignored, rc in use stays on
      wb(1'b1, ccs_pkg::CTL_OFS, 4'b0101, 32'h0001_0080);
      stuck <= 1'b1;
      wait_n(3);
      `CHK({mon, xen, frc_en, nmi}, 4'b0110)
      @(posedge clk_i);
      stuck <= 1'b0;
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, ccs_pkg::CFG0_OFS, 4'hF, 32'((c << 4) | ((c % 4) << 12)));
         pipe.delete();
         repeat (6) begin
            @(posedge clk_i);
            n = $random(seed);
            lv <= n[4:0];
            pipe.push_back({exp_a(c, n[4:0]), exp_b(c % 4, n[4:0])});
            @(negedge clk_i);
            if (pipe.size() > 1) `CHK({ca, cb}, pipe.pop_front())
         end
      end
      // 16 source rises per run, so the count of output rises is exact at any phase
      for (int d = 1; d < 4; d++) begin
         wb(1'b1, ccs_pkg::CFG0_OFS, 4'hF, 32'((d << 8) | (1 << 12) | (d << 16)));
         lv <= 5'h00;
         wait_n(4);
         na = 0;
         nb = 0;
         pa = ca;
         pb = cb;
         for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            if (i < 32) lv[0] <= ~lv[0];
            @(negedge clk_i);
            na += int'(ca === 1'b1 && pa === 1'b0);
            nb += int'(cb === 1'b1 && pb === 1'b0);
            pa = ca;
            pb = cb;
         end
         `CHK(na, 16 >> d)
         `CHK(nb, 16 >> d)
      end
      wb(1'b1, ccs_pkg::LRC_OFS, 4'hF, 32'h0000_0001);
      @(posedge clk_i);
      lstb <= 1'b1;
      wait_n(3);
      `CHK({lrc_en, lirq}, 2'b10)
      wb(1'b0, ccs_pkg::INT_OFS, 4'hF, 32'h0000_0000);
      `CHK(q[0], 1'b1)
      wb(1'b1, ccs_pkg::INT_OFS, 4'hF, 32'h0000_0100);
      wait_n(2);
      `CHK(lirq, 1'b1)
      @(posedge clk_i);
      lstb <= 1'b0;
      wb(1'b1, ccs_pkg::INT_OFS, 4'hF, 32'h0001_0100);
      wait_n(2);
      `CHK(lirq, 1'b0)
      for (int c = 1; c < 5; c++) begin
         wb(1'b1, ccs_pkg::VKEY_OFS, 4'hF, ccs_pkg::VKEY_UNLOCK);
         wb(1'b1, ccs_pkg::DSV_OFS, 4'hF, 32'(c % 4));
         wait_n(2);
         `CHK(dlvl, (c % 4 == 3) ? 2'h2 : 2'(c % 4))
      end
      wb(1'b1, ccs_pkg::DSV_OFS, 4'hF, 32'h0000_0001);
      wait_n(2);
      `CHK(dlvl, 2'h0)
      @(posedge clk_i);
      sleep <= 1'b1;
      @(posedge clk_i);
      sleep <= 1'b0;
      wait_n(2);
      `CHK({xpu, xen}, 2'b00)
      wb(1'b0, 8'h40, 4'hF, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      end_sim();
   end
endmodule

// *** src/ccs_top.sv ***
`timescale 1ns/100ps

// Behaviour
// - low-speed rc enable, stable flag, interrupt
// - system clock starts on fast rc
// - switch only once target reports stable
// - writes cannot stop oscillator driving system clock
// - failure clears crystal enable, sets flag
// - failure event drives non-maskable interrupt
// - failed crystal in use forces rc, pll off
// - failed crystal as pll reference stops pll
// - output a select decodes six sources
// - output b select decodes four sources
// - each clock output has binary divider
// - deep-sleep field selects core voltage level
// - voltage register writable only after key
// - control at 0x00, byte/half/word access
// - ready bit writable only while crystal off
// - power-up bit guarded, cleared on sleep
// - pll stable flag read-only at 23
// - bit 22 enables the crystal monitor
// - pll enable clear ignored while pll sysclk
// - failure sets fast rc enable
module ccs_top (
   input  wire logic        clk_i,            // 125 MHz system clock
   input  wire logic        rst_i,            // synchronous reset, high
   input  wire logic        cyc_i,            // wishbone cycle
   input  wire logic        stb_i,            // wishbone strobe
   input  wire logic        we_i,             // wishbone write
   input  wire logic [7:0]  adr_i,            // wishbone byte address
   input  wire logic [3:0]  sel_i,            // wishbone byte lanes
   input  wire logic [31:0] dat_i,            // wishbone write data
   output logic [31:0]      dat_o,            // wishbone read data
   output logic             ack_o,            // wishbone acknowledge
   input  wire logic        frc_stable_i,     // fast rc stable
   input  wire logic        xtal_stable_i,    // crystal stable
   input  wire logic        pll_stable_i,     // pll output stable
   input  wire logic        lrc_stable_i,     // low-speed rc stable
   input  wire logic        pll_ref_xtal_i,   // pll fed from crystal
   input  wire logic        xtal_stuck_i,     // crystal seen stuck
   input  wire logic        sleep_entry_i,    // deep-sleep/standby entry pulse
   input  wire logic        frc_lvl_i,        // sampled fast rc level
   input  wire logic        sxtal_lvl_i,      // sampled slow crystal level
   input  wire logic        xtal_lvl_i,       // sampled crystal level
   input  wire logic        pll_lvl_i,        // sampled pll level
   input  wire logic        lrc_lvl_i,        // sampled low-speed rc level
   output logic             frc_en_o,         // fast rc enable
   output logic             xtal_en_o,        // crystal enable
   output logic             xtal_pu_o,        // crystal power-up
   output logic             xtal_ready_o,     // crystal ready bit
   output logic             pll_en_o,         // pll enable
   output logic             mon_en_o,         // crystal monitor enable
   output logic             lrc_en_o,         // low-speed rc enable
   output logic [1:0]       sysclk_src_o,     // system clock source
   output logic             lrc_irq_o,        // low-speed rc stable irq
   output logic             nmi_o,            // crystal failure nmi pulse
   output logic             clkout_a_o,       // clock output a
   output logic             clkout_b_o,       // clock output b
   output logic [1:0]       dsleep_level_o,   // deep-sleep core level code
   output logic [4:0]       frc_trim_o        // fast rc trim adjust
);

   localparam int DIVW = 7;

   ccs_pkg::ccs_src_t cur_q;
   ccs_pkg::ccs_src_t sw_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        xen_q, pu_q, ready_q, pllen_q, monen_q, fen_q, lrcen_q;
   logic [4:0]  adj_q;
   logic [2:0]  asel_q, adiv_q, bdiv_q;
   logic [1:0]  bsel_q;
   logic        lrcf_q, ckmf_q, lrcie_q, lrc_prev_q;
   logic        irq_q, nmi_q;
   logic        unlock_q;
   logic [1:0]  dsv_q, lvl_q;
   logic [31:0] ctl_rd, cfg_rd, int_rd, lrc_rd, rd_mux, wv;
   logic        req, wr_en, ctl_wr, cfg_wr, int_wr, lrc_wr, dsv_wr, key_wr;
   logic        fail_ev, xtal_used, frc_used, tgt_stable;
   logic        sys_lvl;
   logic [1:0]  ch_lvl;
   logic [2:0]  ch_div [2];
   logic [1:0]  ch_out_q;

   // bus slave: ack one cycle after request, write commits on the ack edge
   assign req    = cyc_i && stb_i;
   assign wr_en  = req && we_i && ack_q;
   assign ctl_wr = wr_en && adr_i == ccs_pkg::CTL_OFS;
   assign cfg_wr = wr_en && adr_i == ccs_pkg::CFG0_OFS;
   assign int_wr = wr_en && adr_i == ccs_pkg::INT_OFS;
   assign lrc_wr = wr_en && adr_i == ccs_pkg::LRC_OFS;
   assign dsv_wr = wr_en && adr_i == ccs_pkg::DSV_OFS;
   assign key_wr = wr_en && adr_i == ccs_pkg::VKEY_OFS;

   always_comb begin
      ctl_rd = 32'h0000_0000;
      ctl_rd[ccs_pkg::CTL_READY_BIT]  = ready_q;
      ctl_rd[ccs_pkg::CTL_PU_BIT]     = pu_q;
      ctl_rd[ccs_pkg::CTL_PLLSTB_BIT] = pll_stable_i;
      ctl_rd[ccs_pkg::CTL_MONEN_BIT]  = monen_q;
      ctl_rd[ccs_pkg::CTL_PLLEN_BIT]  = pllen_q;
      ctl_rd[ccs_pkg::CTL_XSTB_BIT]   = xtal_stable_i;
      ctl_rd[ccs_pkg::CTL_XEN_BIT]    = xen_q;
      ctl_rd[ccs_pkg::CTL_ADJ_LSB +: 5] = adj_q;
      ctl_rd[ccs_pkg::CTL_FSTB_BIT]   = frc_stable_i;
      ctl_rd[ccs_pkg::CTL_FEN_BIT]    = fen_q;
      cfg_rd = 32'h0000_0000;
      cfg_rd[ccs_pkg::CFG_SW_LSB +: 2]   = sw_q;
      cfg_rd[ccs_pkg::CFG_STAT_LSB +: 2] = cur_q;
      cfg_rd[ccs_pkg::CFG_ASEL_LSB +: 3] = asel_q;
      cfg_rd[ccs_pkg::CFG_ADIV_LSB +: 3] = adiv_q;
      cfg_rd[ccs_pkg::CFG_BSEL_LSB +: 2] = bsel_q;
      cfg_rd[ccs_pkg::CFG_BDIV_LSB +: 3] = bdiv_q;
      int_rd = 32'h0000_0000;
      int_rd[ccs_pkg::INT_LRCF_BIT]  = lrcf_q;
      int_rd[ccs_pkg::INT_CKMF_BIT]  = ckmf_q;
      int_rd[ccs_pkg::INT_LRCIE_BIT] = lrcie_q;
      lrc_rd = 32'h0000_0000;
      lrc_rd[ccs_pkg::LRC_EN_BIT]  = lrcen_q;
      lrc_rd[ccs_pkg::LRC_STB_BIT] = lrc_stable_i;
      case (adr_i)
         ccs_pkg::CTL_OFS:  rd_mux = ctl_rd;
         ccs_pkg::CFG0_OFS: rd_mux = cfg_rd;
         ccs_pkg::INT_OFS:  rd_mux = int_rd;
         ccs_pkg::LRC_OFS:  rd_mux = lrc_rd;
         ccs_pkg::DSV_OFS:  rd_mux = {30'h0, dsv_q};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   // byte lanes merge into the current value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wv[8*i +: 8] = sel_i[i] ? dat_i[8*i +: 8] : rd_mux[8*i +: 8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= req && !ack_q;
         rdat_q <= (req && !ack_q && !we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // the monitor only fires while the crystal is still on, so one event per failure
   assign fail_ev   = monen_q && xen_q && xtal_stuck_i;
   assign xtal_used = cur_q == ccs_pkg::CCS_SRC_XTAL || (cur_q == ccs_pkg::CCS_SRC_PLL && pll_ref_xtal_i);
   assign frc_used  = cur_q == ccs_pkg::CCS_SRC_RC || (cur_q == ccs_pkg::CCS_SRC_PLL && !pll_ref_xtal_i);

   always_comb begin
      case (sw_q)
         ccs_pkg::CCS_SRC_RC:   tgt_stable = frc_stable_i;
         ccs_pkg::CCS_SRC_XTAL: tgt_stable = xtal_stable_i;
         ccs_pkg::CCS_SRC_PLL:  tgt_stable = pll_stable_i;
         default:               tgt_stable = 1'b0;
      endcase
   end

   // system clock source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_q <= ccs_pkg::CCS_SRC_RC;
         sw_q  <= ccs_pkg::CCS_SRC_RC;
      end else if (fail_ev && xtal_used) begin
         // single step, never via another source
         cur_q <= ccs_pkg::CCS_SRC_RC;
         sw_q  <= ccs_pkg::CCS_SRC_RC;
      end else begin
         if (cfg_wr) begin
            sw_q <= ccs_pkg::ccs_src_t'(wv[ccs_pkg::CFG_SW_LSB +: 2]);
         end
         if (sw_q != cur_q && tgt_stable) begin
            cur_q <= sw_q;
         end
      end
   end

   // crystal enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xen_q <= 1'b0;
      end else if (fail_ev || sleep_entry_i) begin
         xen_q <= 1'b0;
      end else if (ctl_wr) begin
         xen_q <= wv[ccs_pkg::CTL_XEN_BIT] || (xen_q && xtal_used);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fen_q <= ccs_pkg::FEN_RST;
      end else if (fail_ev) begin
         fen_q <= 1'b1;
      end else if (ctl_wr) begin
         fen_q <= wv[ccs_pkg::CTL_FEN_BIT] || (fen_q && frc_used);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pllen_q <= 1'b0;
      end else if ((fail_ev && (pll_ref_xtal_i || xtal_used)) || sleep_entry_i) begin
         // pll stops with crystal in use
         pllen_q <= 1'b0;
      end else if (ctl_wr) begin
         // clear ignored while pll is sysclk
         pllen_q <= wv[ccs_pkg::CTL_PLLEN_BIT] || (pllen_q && cur_q == ccs_pkg::CCS_SRC_PLL);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pu_q    <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         if (sleep_entry_i) begin
            pu_q <= 1'b0;
         end else if (ctl_wr && !xen_q) begin
            pu_q <= wv[ccs_pkg::CTL_PU_BIT];
         end
         if (ctl_wr && !xen_q) begin
            ready_q <= wv[ccs_pkg::CTL_READY_BIT];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         monen_q <= ccs_pkg::MONEN_RST;
         adj_q   <= ccs_pkg::ADJ_RST;
      end else if (ctl_wr) begin
         monen_q <= wv[ccs_pkg::CTL_MONEN_BIT];
         adj_q   <= wv[ccs_pkg::CTL_ADJ_LSB +: 5];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         asel_q <= 3'h0;
         adiv_q <= 3'h0;
         bsel_q <= 2'h0;
         bdiv_q <= 3'h0;
      end else if (cfg_wr) begin
         asel_q <= wv[ccs_pkg::CFG_ASEL_LSB +: 3];
         adiv_q <= wv[ccs_pkg::CFG_ADIV_LSB +: 3];
         bsel_q <= wv[ccs_pkg::CFG_BSEL_LSB +: 2];
         bdiv_q <= wv[ccs_pkg::CFG_BDIV_LSB +: 3];
      end
   end

   // flags: a set in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lrcf_q     <= 1'b0;
         ckmf_q     <= 1'b0;
         lrcie_q    <= 1'b0;
         lrc_prev_q <= 1'b0;
         lrcen_q    <= 1'b0;
         irq_q      <= 1'b0;
         nmi_q      <= 1'b0;
      end else begin
         lrc_prev_q <= lrc_stable_i;
         if (lrc_stable_i && !lrc_prev_q) begin
            lrcf_q <= 1'b1;
         end else if (int_wr && sel_i[2] && dat_i[ccs_pkg::INT_LRCCLR_BIT]) begin
            lrcf_q <= 1'b0;
         end
         if (fail_ev) begin
            ckmf_q <= 1'b1;
         end else if (int_wr && sel_i[2] && dat_i[ccs_pkg::INT_CKMCLR_BIT]) begin
            ckmf_q <= 1'b0;
         end
         if (int_wr) begin
            lrcie_q <= wv[ccs_pkg::INT_LRCIE_BIT];
         end
         if (lrc_wr) begin
            lrcen_q <= wv[ccs_pkg::LRC_EN_BIT];
         end
         irq_q <= lrcf_q && lrcie_q;
         nmi_q <= fail_ev;
      end
   end

   // deep-sleep voltage with key
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unlock_q <= 1'b0;
         dsv_q    <= ccs_pkg::DSV_RST;
         lvl_q    <= ccs_pkg::LVL_1V1;
      end else begin
         if (key_wr) begin
            unlock_q <= wv == ccs_pkg::VKEY_UNLOCK;
         end else if (dsv_wr) begin
            unlock_q <= 1'b0;
         end
         if (dsv_wr && unlock_q) begin
            dsv_q <= wv[1:0];
         end
         case (dsv_q)
            2'h0:    lvl_q <= ccs_pkg::LVL_1V1;
            2'h1:    lvl_q <= ccs_pkg::LVL_1V0;
            default: lvl_q <= ccs_pkg::LVL_0V9;
         endcase
      end
   end

   // clock outputs work on sampled source levels, so the pin rate is bounded by clk_i/2
   always_comb begin
      case (cur_q)
         ccs_pkg::CCS_SRC_XTAL: sys_lvl = xtal_lvl_i;
         ccs_pkg::CCS_SRC_PLL:  sys_lvl = pll_lvl_i;
         default:               sys_lvl = frc_lvl_i;
      endcase
      case (asel_q)
         3'h0:    ch_lvl[0] = frc_lvl_i;
         3'h1:    ch_lvl[0] = sxtal_lvl_i;
         3'h2:    ch_lvl[0] = xtal_lvl_i;
         3'h3:    ch_lvl[0] = pll_lvl_i;
         3'h4:    ch_lvl[0] = lrc_lvl_i;
         3'h5:    ch_lvl[0] = sys_lvl;
         default: ch_lvl[0] = 1'b0;
      endcase
      case (bsel_q)
         2'h0:    ch_lvl[1] = sys_lvl;
         2'h1:    ch_lvl[1] = frc_lvl_i;
         2'h2:    ch_lvl[1] = xtal_lvl_i;
         default: ch_lvl[1] = pll_lvl_i;
      endcase
      ch_div[0] = adiv_q;
      ch_div[1] = bdiv_q;
   end

   for (genvar c = 0; c < 2; c++) begin : g_out
      logic            prev_q;
      logic [DIVW-1:0] cnt_q;
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            prev_q      <= 1'b0;
            cnt_q       <= '0;
            ch_out_q[c] <= 1'b0;
         end else begin
            prev_q <= ch_lvl[c];
            if (ch_lvl[c] && !prev_q) begin
               cnt_q <= cnt_q + 1'b1;
            end
            if (ch_div[c] == 3'h0) begin
               ch_out_q[c] <= ch_lvl[c];
            end else begin
               ch_out_q[c] <= cnt_q[ch_div[c] - 3'h1];
            end
         end
      end
   end

   assign dat_o          = rdat_q;
   assign ack_o          = ack_q;
   assign frc_en_o       = fen_q;
   assign xtal_en_o      = xen_q;
   assign xtal_pu_o      = pu_q;
   assign xtal_ready_o   = ready_q;
   assign pll_en_o       = pllen_q;
   assign mon_en_o       = monen_q;
   assign lrc_en_o       = lrcen_q;
   assign sysclk_src_o   = cur_q;
   assign lrc_irq_o      = irq_q;
   assign nmi_o          = nmi_q;
   assign clkout_a_o     = ch_out_q[0];
   assign clkout_b_o     = ch_out_q[1];
   assign dsleep_level_o = lvl_q;
   assign frc_trim_o     = adj_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_nmi_pulse;
      nmi_o ##1 !nmi_o;
   endsequence

   property p_lrc_irq;
      lrcf_q && lrcie_q |=> lrc_irq_o;
   endproperty
   a_lrc_irq: assert property (p_lrc_irq) else $error("stable irq missing");

   property p_switch_cause;
      $changed(cur_q) |-> $past(tgt_stable) || $past(fail_ev);
   endproperty
   a_switch_cause: assert property (p_switch_cause) else $error("source changed without cause");

   property p_xtal_kept;
      xen_q && xtal_used && !fail_ev && !sleep_entry_i |=> xen_q;
   endproperty
   a_xtal_kept: assert property (p_xtal_kept) else $error("in-use crystal stopped");

   property p_fail_flags;
      fail_ev |=> !xen_q && ckmf_q && fen_q;
   endproperty
   a_fail_flags: assert property (p_fail_flags) else $error("failure effects missing");

   property p_fail_nmi;
      fail_ev |=> s_nmi_pulse;
   endproperty
   a_fail_nmi: assert property (p_fail_nmi) else $error("nmi pulse wrong");

   property p_fallback;
      fail_ev && xtal_used |=> cur_q == ccs_pkg::CCS_SRC_RC && !pllen_q;
   endproperty
   a_fallback: assert property (p_fallback) else $error("no fallback to rc");

   property p_pll_ref;
      fail_ev && pll_ref_xtal_i |=> !pllen_q;
   endproperty
   a_pll_ref: assert property (p_pll_ref) else $error("pll left running");

   property p_dsv_lock;
      dsv_wr && !unlock_q |=> $stable(dsv_q);
   endproperty
   a_dsv_lock: assert property (p_dsv_lock) else $error("locked voltage written");

   property p_ready_guard;
      ctl_wr && xen_q |=> $stable(ready_q);
   endproperty
   a_ready_guard: assert property (p_ready_guard) else $error("ready changed while on");

   property p_pll_hold;
      pllen_q && cur_q == ccs_pkg::CCS_SRC_PLL && !fail_ev && !sleep_entry_i |=> pllen_q;
   endproperty
   a_pll_hold: assert property (p_pll_hold) else $error("pll cleared while sysclk");

endmodule
